// file: hdl/dtcr_top.sv
// dual up/down timer with toggle latch and capture/reload register
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - finest count step is two clocks
// - each timer counts prescaled clock or pin
// - direction from software, optionally flipped by pin
// - toggle latch flips on each core wrap
// - latch clocks aux timer and drives pin
// - core wraps clock the compare unit timers
// - core wrap optionally triggers reload from capture register
// - selected capture pin edge copies aux count
// - optionally clear aux timer after capture
// - neighbour timer inputs may trigger capture
module dtcr_top
  import dtcr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [AW-1:0] regAddr,
  input wire logic [CW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [CW-1:0] regRdata,
  // external count and direction pins
  input wire logic auxCountPin,
  input wire logic coreCountPin,
  input wire logic auxDirPin,
  input wire logic coreDirPin,
  // capture sources
  input wire logic captureInputPin,
  input wire logic neighbourCountInput,
  input wire logic neighbourDirectionInput,
  // outputs
  output logic toggleLatchOutPin,
  output logic toggleLatchOutPinOe,
  output logic compareUnitClk
);
  //////////////////////////////////////////////////////////////////////
  // declarations
  dtcr_tctl_s auxCtl_ff;
  dtcr_tctl_s coreCtl_ff;
  dtcr_cctl_s capCtl_ff;
  logic [CW-1:0] capReload_ff;
  logic [PRE_W-1:0] preCnt_ff;
  logic toggle_ff;
  logic ovfPulse_ff;
  logic [CW-1:0] rdata_ff;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] pinLvl;
  logic [NPIN-1:0] pinRise;
  logic [NPIN-1:0] pinFall;
  logic auxTick;
  logic coreTick;
  logic auxDown;
  logic coreDown;
  logic auxLd;
  logic coreLd;
  logic [CW-1:0] auxLdVal;
  logic [CW-1:0] coreLdVal;
  logic [CW-1:0] auxCnt;
  logic [CW-1:0] coreCnt;
  logic auxWrap;
  logic coreWrap;
  logic reload;
  logic capRise;
  logic capFall;
  logic capHit;
  logic capClr;
  logic swAuxWr;
  logic swCoreWr;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pinRaw = {neighbourDirectionInput, neighbourCountInput,
                   captureInputPin, coreDirPin, auxDirPin,
                   coreCountPin, auxCountPin};

  dtcr_pin_sync #(
    .W(NPIN)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pinIn(pinRaw),
    .level(pinLvl),
    .rise(pinRise),
    .fall(pinFall)
  );

  //////////////////////////////////////////////////////////////////////
  // prescaler
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      preCnt_ff <= '0;
    end else begin
      preCnt_ff <= preCnt_ff + 8'h01;
    end
  end

  // one tick every 2 << exp clocks, never fewer than two
  function automatic logic pre_tick(input logic [2:0] exp,
                                    input logic [PRE_W-1:0] cnt);
    logic [PRE_W:0] mask;
    mask = (9'h002 << exp) - 9'h001;
    return &(cnt | ~mask[PRE_W-1:0]);
  endfunction : pre_tick

  // count clock selection per timer
  function automatic logic sel_tick(input dtcr_tctl_s ctl,
                                    input logic [PRE_W-1:0] cnt,
                                    input logic pinEdge,
                                    input logic latchEvt);
    logic t;
    t = 1'b0;
    case (ctl.clkSrc)
      CS_PRESCALE: t = pre_tick(ctl.preExp, cnt);
      CS_EXT_PIN: t = pinEdge;
      CS_TOGGLE: t = latchEvt;
      CS_OFF: t = 1'b0;
      default: t = 1'b0;
    endcase
    return ctl.run & t;
  endfunction : sel_tick

  //////////////////////////////////////////////////////////////////////
  // tick and direction
  // latch-driven counting concatenates core into aux
  assign auxTick = sel_tick(auxCtl_ff, preCnt_ff, pinRise[PIN_AUX_CNT],
                            ovfPulse_ff);
  assign coreTick = sel_tick(coreCtl_ff, preCnt_ff,
                             pinRise[PIN_CORE_CNT], 1'b0);

  assign auxDown = auxCtl_ff.down ^
                   (auxCtl_ff.extDirEn & pinLvl[PIN_AUX_DIR]);
  assign coreDown = coreCtl_ff.down ^
                    (coreCtl_ff.extDirEn & pinLvl[PIN_CORE_DIR]);

  //////////////////////////////////////////////////////////////////////
  // capture trigger
  always_comb begin
    capRise = 1'b0;
    capFall = 1'b0;
    case (capCtl_ff.src)
      CP_PIN: begin
        capRise = pinRise[PIN_CAP];
        capFall = pinFall[PIN_CAP];
      end
      CP_NBR_CNT: begin
        capRise = pinRise[PIN_NBR_CNT];
        capFall = pinFall[PIN_NBR_CNT];
      end
      CP_NBR_DIR: begin
        capRise = pinRise[PIN_NBR_DIR];
        capFall = pinFall[PIN_NBR_DIR];
      end
      CP_NBR_BOTH: begin
        capRise = pinRise[PIN_NBR_CNT] | pinRise[PIN_NBR_DIR];
        capFall = pinFall[PIN_NBR_CNT] | pinFall[PIN_NBR_DIR];
      end
      default: begin
        capRise = 1'b0;
        capFall = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (capCtl_ff.capEdge)
      CE_RISE: capHit = capRise;
      CE_FALL: capHit = capFall;
      CE_BOTH: capHit = capRise | capFall;
      default: capHit = 1'b0;
    endcase
  end

  assign capClr = capHit & capCtl_ff.clearAfter;

  //////////////////////////////////////////////////////////////////////
  // timers
  assign swAuxWr = regWr & (regAddr == OFS_AUX_CNT);
  assign swCoreWr = regWr & (regAddr == OFS_CORE_CNT);

  // clear after capture wins over a software write
  assign auxLd = capClr | swAuxWr;
  assign auxLdVal = capClr ? 16'h0000 : regWdata;

  // hardware reload wins over a software write
  assign reload = coreWrap & coreCtl_ff.reloadEn;
  assign coreLd = reload | swCoreWr;
  assign coreLdVal = reload ? capReload_ff : regWdata;

  dtcr_timer u_aux (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(auxTick),
    .down(auxDown),
    .load(auxLd),
    .loadVal(auxLdVal),
    .count(auxCnt),
    .wrap(auxWrap)
  );

  dtcr_timer u_core (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(coreTick),
    .down(coreDown),
    .load(coreLd),
    .loadVal(coreLdVal),
    .count(coreCnt),
    .wrap(coreWrap)
  );

  //////////////////////////////////////////////////////////////////////
  // toggle latch and compare-unit clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_ff <= 1'b0;
    end else if (coreWrap) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovfPulse_ff <= 1'b0;
    end else begin
      ovfPulse_ff <= coreWrap;
    end
  end

  assign compareUnitClk = ovfPulse_ff;
  assign toggleLatchOutPin = toggle_ff;
  assign toggleLatchOutPinOe = coreCtl_ff.toggleOutEn;

  //////////////////////////////////////////////////////////////////////
  // capture/reload register, capture wins over a software write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      capReload_ff <= RST_CAP_RELOAD;
    end else if (capHit) begin
      capReload_ff <= auxCnt;
    end else if (regWr && regAddr == OFS_CAP_RELOAD) begin
      capReload_ff <= regWdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      auxCtl_ff <= RST_CTL;
    end else if (regWr && regAddr == OFS_AUX_CTL) begin
      auxCtl_ff <= regWdata & TCTL_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreCtl_ff <= RST_CTL;
    end else if (regWr && regAddr == OFS_CORE_CTL) begin
      coreCtl_ff <= regWdata & TCTL_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      capCtl_ff <= RST_CTL;
    end else if (regWr && regAddr == OFS_CAP_CTL) begin
      capCtl_ff <= regWdata & CCTL_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFS_AUX_CTL: rdata_ff <= auxCtl_ff;
        OFS_CORE_CTL: rdata_ff <= coreCtl_ff;
        OFS_AUX_CNT: rdata_ff <= auxCnt;
        OFS_CORE_CNT: rdata_ff <= coreCnt;
        OFS_CAP_RELOAD: rdata_ff <= capReload_ff;
        OFS_CAP_CTL: rdata_ff <= capCtl_ff;
        OFS_STATUS: begin
          rdata_ff <= '0;
          rdata_ff[ST_TOGGLE] <= toggle_ff;
          rdata_ff[ST_AUX_DOWN] <= auxDown;
          rdata_ff[ST_CORE_DOWN] <= coreDown;
        end
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign regRdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_pre_step_gap: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreTick && coreCtl_ff.clkSrc == CS_PRESCALE && $stable(coreCtl_ff)
    |=> !coreTick)
    else $error("prescaled core steps closer than two clocks");

  a_pin_count_up: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    auxCtl_ff.run && auxCtl_ff.clkSrc == CS_EXT_PIN &&
    pinRise[PIN_AUX_CNT] && !auxLd && !auxDown
    |=> auxCnt == $past(auxCnt) + 16'h0001)
    else $error("aux timer missed an external count edge");

  a_pin_dir_flip: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreTick && !coreLd && coreCtl_ff.extDirEn &&
    pinLvl[PIN_CORE_DIR] && !coreCtl_ff.down
    |=> coreCnt == $past(coreCnt) - 16'h0001)
    else $error("direction pin did not turn core timer down");

  a_toggle_flip: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreWrap |=> toggleLatchOutPin != $past(toggleLatchOutPin))
    else $error("toggle latch did not flip on core wrap");

  a_latch_concat: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreWrap && auxCtl_ff.run && auxCtl_ff.clkSrc == CS_TOGGLE &&
    !auxDown ##1 !auxLd && $stable(auxCtl_ff) && !auxDown
    |=> auxCnt == $past(auxCnt, 1) + 16'h0001)
    else $error("aux timer not stepped by toggle latch");

  a_cmp_clock: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreWrap |=> compareUnitClk ##1 !compareUnitClk)
    else $error("compare unit clock pulse wrong");

  a_reload_value: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreWrap && coreCtl_ff.reloadEn |=> coreCnt == $past(capReload_ff))
    else $error("core timer not reloaded on wrap");

  a_no_reload: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    coreWrap && !coreCtl_ff.reloadEn && !swCoreWr && !coreDown
    |=> coreCnt == 16'h0000)
    else $error("core timer changed by reload while disabled");

  a_capture_copy: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    capCtl_ff.src == CP_PIN && capCtl_ff.capEdge == CE_FALL &&
    pinFall[PIN_CAP] |=> capReload_ff == $past(auxCnt))
    else $error("capture pin edge did not copy aux count");

  a_capture_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    capHit && capCtl_ff.clearAfter |=> auxCnt == 16'h0000)
    else $error("aux timer not cleared after capture");

  a_nbr_capture: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    capCtl_ff.src == CP_NBR_CNT && capCtl_ff.capEdge == CE_RISE &&
    pinRise[PIN_NBR_CNT] |=> capReload_ff == $past(auxCnt))
    else $error("neighbour count edge did not capture");
endmodule : dtcr_top
`default_nettype wire

// file: include/dtcr_pkg.sv
// shared constants and carriers for the dual timer with capture/reload
package dtcr_pkg;
  localparam int unsigned CW = 16;
  localparam int unsigned AW = 8;
  localparam int unsigned PRE_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_AUX_CTL = 8'h00;
  localparam logic [7:0] OFS_CORE_CTL = 8'h04;
  localparam logic [7:0] OFS_AUX_CNT = 8'h08;
  localparam logic [7:0] OFS_CORE_CNT = 8'h0c;
  localparam logic [7:0] OFS_CAP_RELOAD = 8'h10;
  localparam logic [7:0] OFS_CAP_CTL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // reset values
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_CAP_RELOAD = 16'h0000;
  // writable bits of each control register, the rest read as zero
  localparam logic [15:0] TCTL_MASK = 16'h03ff;
  localparam logic [15:0] CCTL_MASK = 16'h001f;
  // status field positions
  localparam int unsigned ST_TOGGLE = 0;
  localparam int unsigned ST_AUX_DOWN = 1;
  localparam int unsigned ST_CORE_DOWN = 2;
  // synchronised pin indices
  localparam int unsigned PIN_AUX_CNT = 0;
  localparam int unsigned PIN_CORE_CNT = 1;
  localparam int unsigned PIN_AUX_DIR = 2;
  localparam int unsigned PIN_CORE_DIR = 3;
  localparam int unsigned PIN_CAP = 4;
  localparam int unsigned PIN_NBR_CNT = 5;
  localparam int unsigned PIN_NBR_DIR = 6;
  localparam int unsigned NPIN = 7;

  typedef enum logic [1:0] {
    CS_PRESCALE = 2'b00,
    CS_EXT_PIN = 2'b01,
    CS_TOGGLE = 2'b10,
    CS_OFF = 2'b11
  } dtcr_clksrc_e;

  typedef enum logic [1:0] {
    CE_NONE = 2'b00,
    CE_RISE = 2'b01,
    CE_FALL = 2'b10,
    CE_BOTH = 2'b11
  } dtcr_edge_e;

  typedef enum logic [1:0] {
    CP_PIN = 2'b00,
    CP_NBR_CNT = 2'b01,
    CP_NBR_DIR = 2'b10,
    CP_NBR_BOTH = 2'b11
  } dtcr_capsrc_e;

  typedef struct packed {
    logic [5:0] rsvd;
    logic toggleOutEn;
    logic reloadEn;
    logic run;
    logic extDirEn;
    logic down;
    dtcr_clksrc_e clkSrc;
    logic [2:0] preExp;
  } dtcr_tctl_s;

  typedef struct packed {
    logic [10:0] rsvd;
    logic clearAfter;
    dtcr_capsrc_e src;
    dtcr_edge_e capEdge;
  } dtcr_cctl_s;
endpackage : dtcr_pkg

// file: hdl/dtcr_pin_sync.sv
// two-stage synchroniser with edge detect for a group of pins
`timescale 1ns/1ps
`default_nettype none
module dtcr_pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw pins
  input wire logic [W-1:0] pinIn,
  // synchronised view
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= pinIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule : dtcr_pin_sync
`default_nettype wire

// file: hdl/dtcr_timer.sv
// one 16-bit up/down timer with load and wrap event
`timescale 1ns/1ps
`default_nettype none
module dtcr_timer
  import dtcr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // count control
  input wire logic tick,
  input wire logic down,
  input wire logic load,
  input wire logic [CW-1:0] loadVal,
  // state
  output logic [CW-1:0] count,
  output logic wrap
);
  logic [CW-1:0] cnt_ff;

  // load beats a count step taken in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= RST_CNT;
    end else if (load) begin
      cnt_ff <= loadVal;
    end else if (tick) begin
      cnt_ff <= down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
    end
  end

  assign count = cnt_ff;
  // overflow going up, underflow going down
  assign wrap = tick & (down ? (cnt_ff == 16'h0000) : (&cnt_ff));
endmodule : dtcr_timer
`default_nettype wire

// file: bench/dtcr_pin_model.sv
// port pins and neighbouring timer inputs driven toward the timer block
`timescale 1ns/1ps
`default_nettype none
module dtcr_pin_model (
  // clock
  input wire logic ref_clk,
  // pin levels toward the block
  output logic [6:0] pins
);
  initial pins = 7'h00;
  // pins change only just after a clock edge
  task automatic set_pin(input int idx, input logic val);
    @(posedge ref_clk);
    pins[idx] <= val;
  endtask : set_pin
  // one count pulse, two clocks high and two low, so the edge detector sees it
  task automatic pulse(input int idx);
    set_pin(idx, 1'b1);
    repeat (2) @(posedge ref_clk);
    pins[idx] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse
endmodule : dtcr_pin_model
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the dual timer with capture/reload
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dtcr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [AW-1:0] regAddr = '0;
  logic [CW-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [CW-1:0] regRdata;
  logic [6:0] pins;
  logic toggleLatchOutPin;
  logic toggleLatchOutPinOe;
  logic compareUnitClk;
  int mismatches = 0;
  int cmp_count = 0;
  int wrapCount = 0;
  int pin;
  logic [15:0] rnd = 16'h0020;
  logic [15:0] v0;
  logic [15:0] v1;
  logic [15:0] base;
  logic [15:0] expCap;
  logic [15:0] expAux;
  logic d;
  logic e;
  logic pv;
  logic c;
  logic t0;
  logic effDown;
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) if (compareUnitClk === 1'b1) wrapCount++;
  dtcr_pin_model pm (.ref_clk(ref_clk), .pins(pins));
  dtcr_top DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .auxCountPin(pins[PIN_AUX_CNT]), .coreCountPin(pins[PIN_CORE_CNT]),
    .auxDirPin(pins[PIN_AUX_DIR]), .coreDirPin(pins[PIN_CORE_DIR]),
    .captureInputPin(pins[PIN_CAP]), .neighbourCountInput(pins[PIN_NBR_CNT]),
    .neighbourDirectionInput(pins[PIN_NBR_DIR]), .toggleLatchOutPin(toggleLatchOutPin),
    .toggleLatchOutPinOe(toggleLatchOutPinOe), .compareUnitClk(compareUnitClk)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] tctl(input logic [2:0] pe, input dtcr_clksrc_e cs,
      input logic dn, input logic ed, input logic rn, input logic rl, input logic te);
    dtcr_tctl_s s;
    s = '0;
    s.preExp = pe;
    s.clkSrc = cs;
    s.down = dn;
    s.extDirEn = ed;
    s.run = rn;
    s.reloadEn = rl;
    s.toggleOutEn = te;
    return s;
  endfunction : tctl
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [15:0] dv);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= dv;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] dv);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    dv = regRdata;
  endtask : rd
  task automatic wait_wrap();
    int n;
    n = 0;
    @(negedge ref_clk);
    while (compareUnitClk !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_wrap
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk("pin at reset", 16'h0, {14'h0, toggleLatchOutPin, toggleLatchOutPinOe});
    for (int a = 0; a < 8; a++) begin
      rd(8'(a * 4), v0);
      chk("reset value", 16'h0, v0);
    end
    wr(OFS_AUX_CTL, 16'hffff);
    rd(OFS_AUX_CTL, v0);
    chk("ctl mask", TCTL_MASK, v0);
    wr(OFS_CAP_CTL, 16'hffff);
    rd(OFS_CAP_CTL, v0);
    chk("cap ctl mask", CCTL_MASK, v0);
    wr(OFS_AUX_CTL, 16'h0);
    wr(OFS_CAP_CTL, 16'h0);
    wr(OFS_STATUS, 16'hffff);
    wr(8'h1c, 16'hffff);
    rd(OFS_STATUS, v0);
    chk("status read only", 16'h0, v0);
    rd(8'h1c, v0);
    chk("unmapped", 16'h0, v0);
    $display("test registers done");
    // prescaled stepping and direction, both timers
    for (int t = 0; t < 2; t++) begin
      for (int p = 0; p < 4; p++) begin
        rnd = lfsr(rnd);
        d = rnd[0];
        e = rnd[1];
        pv = rnd[2];
        pm.set_pin(t ? PIN_CORE_DIR : PIN_AUX_DIR, pv);
        wr(t ? OFS_CORE_CTL : OFS_AUX_CTL, tctl(3'(p), CS_PRESCALE, d, e, 1'b1, 1'b0, 1'b0));
        repeat (4) @(posedge ref_clk);
        rd(t ? OFS_CORE_CNT : OFS_AUX_CNT, v0);
        repeat (62) @(posedge ref_clk);
        rd(t ? OFS_CORE_CNT : OFS_AUX_CNT, v1);
        effDown = d ^ (e & pv);
        chk("count step", 16'(64 >> (p + 1)), effDown ? v0 - v1 : v1 - v0);
        rd(OFS_STATUS, v0);
        chk("status dir", {15'h0, effDown}, {15'h0, v0[t ? ST_CORE_DOWN : ST_AUX_DOWN]});
        wr(t ? OFS_CORE_CTL : OFS_AUX_CTL, 16'h0);
      end
      rnd = lfsr(rnd);
      wr(t ? OFS_CORE_CNT : OFS_AUX_CNT, 16'h0);
      wr(t ? OFS_CORE_CTL : OFS_AUX_CTL, tctl(3'h0, CS_EXT_PIN, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
      for (int k = 0; k < 3 + int'(rnd[1:0]); k++) pm.pulse(t ? PIN_CORE_CNT : PIN_AUX_CNT);
      repeat (6) @(posedge ref_clk);
      rd(t ? OFS_CORE_CNT : OFS_AUX_CNT, v0);
      chk("pin count", 16'(3 + rnd[1:0]), v0);
      wr(t ? OFS_CORE_CTL : OFS_AUX_CTL, 16'h0);
    end
    $display("test stepping done");
    // core wrap: toggle, pin enable and reload
    for (int r = 0; r < 2; r++) begin
      rnd = lfsr(rnd);
      d = rnd[0];
      wr(OFS_CAP_RELOAD, 16'h1234);
      wr(OFS_CORE_CNT, d ? 16'h0003 : 16'hfffc);
      @(negedge ref_clk);
      t0 = toggleLatchOutPin;
      wr(OFS_CORE_CTL, tctl(3'h0, CS_PRESCALE, d, 1'b0, 1'b1, r[0], r[0]));
      wait_wrap();
      chk("toggle flip", {15'h0, ~t0}, {15'h0, toggleLatchOutPin});
      chk("toggle oe", {15'h0, r[0]}, {15'h0, toggleLatchOutPinOe});
      rd(OFS_CORE_CNT, v0);
      base = r ? 16'h1234 : (d ? 16'hffff : 16'h0000);
      chk("wrap load", 16'h1, {15'h0, (d ? base - v0 : v0 - base) <= 16'd4});
      wr(OFS_CORE_CTL, 16'h0);
    end
    // aux counts toggle latch changes of a fast reloading core
    wr(OFS_AUX_CNT, 16'h0);
    wr(OFS_AUX_CTL, tctl(3'h0, CS_TOGGLE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
    wr(OFS_CAP_RELOAD, 16'hfff8);
    wr(OFS_CORE_CNT, 16'hfff8);
    wrapCount = 0;
    wr(OFS_CORE_CTL, tctl(3'h0, CS_PRESCALE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1));
    repeat (200) @(posedge ref_clk);
    wr(OFS_CORE_CTL, 16'h0);
    repeat (6) @(posedge ref_clk);
    rd(OFS_AUX_CNT, v0);
    chk("aux by toggle", 16'(wrapCount), v0);
    chk("wraps seen", 16'h1, {15'h0, wrapCount > 8});
    $display("test wrap done");
    // capture from every source and edge choice
    for (int s = 0; s < 4; s++) begin
      for (int g = 0; g < 4; g++) begin
        rnd = lfsr(rnd);
        c = rnd[0];
        pin = (s == 0) ? PIN_CAP : ((s == 2) ? PIN_NBR_DIR : PIN_NBR_CNT);
        wr(OFS_AUX_CTL, 16'h0);
        wr(OFS_AUX_CNT, rnd);
        wr(OFS_CAP_RELOAD, 16'h0);
        wr(OFS_CAP_CTL, {11'h0, c, 2'(s), 2'(g)});
        expCap = 16'h0;
        expAux = rnd;
        for (int lv = 1; lv >= 0; lv--) begin
          pm.set_pin(pin, lv[0]);
          repeat (6) @(posedge ref_clk);
          if (g == (lv ? CE_RISE : CE_FALL) || g == CE_BOTH) begin
            expCap = expAux;
            if (c) expAux = 16'h0;
          end
          rd(OFS_CAP_RELOAD, v0);
          chk("capture value", expCap, v0);
          rd(OFS_AUX_CNT, v0);
          chk("aux after capture", expAux, v0);
        end
      end
    end
    $display("test capture done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
